// ===== shared/apm_pkg.sv
// Purpose: Constants and types for the PM1 event and control byte group
// Assumes: Byte registers at small offsets from a 16-byte aligned I/O base
// Notes:   Offsets are relative to the block base
package apm_pkg;

  localparam int unsigned ADDR_W = 10;
  localparam int unsigned OFF_W  = 4;

  // Byte offsets within the block
  localparam logic [3:0] OFF_STATUS_LOW  = 4'h0;
  localparam logic [3:0] OFF_WAKE_STATUS = 4'h1;
  localparam logic [3:0] OFF_ENABLE_LOW  = 4'h2;
  localparam logic [3:0] OFF_ENABLE_HIGH = 4'h3;
  localparam logic [3:0] OFF_CONTROL_1   = 4'h4;
  localparam logic [3:0] OFF_CONTROL_2   = 4'h5;
  localparam logic [3:0] OFF_CONTROL_3   = 4'h6;

  // Field positions
  localparam int unsigned BIT_TICK_FLAG   = 0;
  localparam int unsigned BIT_BM_FLAG     = 4;
  localparam int unsigned BIT_GBL_FLAG    = 5;
  localparam int unsigned BIT_WAKE_FLAG   = 7;
  localparam int unsigned BIT_TICK_EN     = 0;
  localparam int unsigned BIT_GLOBAL_ATTENTION_ENABLE      = 5;
  localparam int unsigned BIT_ROUTE_SEL   = 0;
  localparam int unsigned BIT_BM_RELOAD   = 1;
  localparam int unsigned BIT_GBL_RELEASE = 2;

  // Reset values
  localparam logic       RST_BIT  = 1'b0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic {
    APM_WORKING,
    APM_SLEEPING
  } apm_state_e;

  // Host I/O access
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } apm_io_s;

endpackage

// ===== src/apm_pm1_event_control.sv
// Purpose: PM1 wake status, enables and control bits with SCI/SMI routing
// Assumes: Host I/O strobes, counter MSB and firmware pulses are on clk
// Notes:   resume_event is a pin and passes a two-flop synchroniser
// Functional notes
// - Wake flag sets when a resume event arrives while sleeping.
// - Setting the wake flag moves the system to the working state.
// - Wake flag set only by hardware; host write one clears, zero keeps.
// - Global standby timer expiry clears the wake flag automatically.
// - Wake flag clear and all devices asleep puts the chip to sleep.
// - Tick enable set makes each tick carry flag setting raise SCI.
// - Tick enable clear means tick carry flag raises no interrupt.
// - Global attention enable and flag both set raise SCI.
// - Route select set sends power management events as SCI.
// - Route select clear with alternate enable set sends them as SMI.
// - Bus master reload enable and request bit both set raise SCI.
// - Writing one to global release also sets the firmware event flag.
// - Global release with firmware enable set raises SMI.
// - Reserved bits and the all-reserved bytes read as zero.
// - Tick carry flag sets on any change of counter bit 23.
// - Global attention flag set by firmware release, cleared by host write one.
// - Host write one to bus master flag clears it and the request bit.
`timescale 1ns/1ns
module apm_pm1_event_control
(
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic [apm_pkg::ADDR_W-1:0]    io_base,
  input  wire apm_pkg::apm_io_s              io_req,
  output logic      [7:0]                    io_rdata,
  input  wire logic                          counter_msb,
  input  wire logic                          resume_event,
  input  wire logic                          all_devices_asleep,
  input  wire logic                          standby_expired,
  input  wire logic                          firmware_release,
  input  wire logic                          busmaster_request_set,
  input  wire logic                          firmware_event_clear,
  input  wire logic                          firmware_event_enable,
  input  wire logic                          alternate_route_enable,
  output logic                               firmware_event_flag,
  output logic                               system_sleeping,
  output logic                               sci,
  output logic                               smi
);

  function automatic logic hit(input logic [apm_pkg::OFF_W-1:0] off,
                               input logic [apm_pkg::OFF_W-1:0] want);
    hit = (off == want);
  endfunction

  logic                   resume_meta_ff;
  logic                   resume_sync_ff;
  logic                   msb_prev_ff;
  apm_pkg::apm_state_e    state_ff;
  apm_pkg::apm_state_e    nxt_state;
  logic                   wake_flag_ff;
  logic                   tick_carry_flag_ff;
  logic                   busmaster_flag_ff;
  logic                   global_attention_flag_ff;
  logic                   tick_event_enable_ff;
  logic                   global_attention_enable_ff;
  logic                   event_route_select_ff;
  logic                   busmaster_reload_enable_ff;
  logic                   global_release_ff;
  logic                   busmaster_request_bit_ff;
  logic                   firmware_event_flag_ff;
  logic                   nxt_wake_flag;
  logic                   nxt_tick_flag;
  logic                   nxt_bm_flag;
  logic                   nxt_bm_request;
  logic                   nxt_gbl_flag;
  logic                   nxt_gbl_release;
  logic                   nxt_fw_flag;
  logic [7:0]             nxt_rdata;

  wire                    in_block  = (io_req.addr[apm_pkg::ADDR_W-1:apm_pkg::OFF_W]
                                       == io_base[apm_pkg::ADDR_W-1:apm_pkg::OFF_W]);
  wire [apm_pkg::OFF_W-1:0] off     = io_req.addr[apm_pkg::OFF_W-1:0];
  wire                    wr_stat0  = io_req.wr & in_block & hit(off, apm_pkg::OFF_STATUS_LOW);
  wire                    wr_wake   = io_req.wr & in_block & hit(off, apm_pkg::OFF_WAKE_STATUS);
  wire                    wr_en_lo  = io_req.wr & in_block & hit(off, apm_pkg::OFF_ENABLE_LOW);
  wire                    wr_ctl1   = io_req.wr & in_block & hit(off, apm_pkg::OFF_CONTROL_1);
  wire                    clr_wake  = wr_wake & io_req.wdata[apm_pkg::BIT_WAKE_FLAG];
  wire                    clr_tick  = wr_stat0 & io_req.wdata[apm_pkg::BIT_TICK_FLAG];
  wire                    clr_bm    = wr_stat0 & io_req.wdata[apm_pkg::BIT_BM_FLAG];
  wire                    clr_gbl   = wr_stat0 & io_req.wdata[apm_pkg::BIT_GBL_FLAG];
  wire                    set_rls   = wr_ctl1 & io_req.wdata[apm_pkg::BIT_GBL_RELEASE];
  wire                    tick_edge = counter_msb ^ msb_prev_ff;
  wire                    wake_set  = (state_ff == apm_pkg::APM_SLEEPING) & resume_sync_ff;
  wire                    pm_event  = (tick_carry_flag_ff & tick_event_enable_ff)
                                    | (global_attention_flag_ff & global_attention_enable_ff)
                                    | (busmaster_reload_enable_ff & busmaster_request_bit_ff);
  wire                    fw_smi    = firmware_event_flag_ff & firmware_event_enable;
  // Whole reserved bytes, watched by the readback check only
  wire                    rd_rsvd   = io_req.rd & in_block
                                    & (hit(off, apm_pkg::OFF_ENABLE_HIGH)
                                    | hit(off, apm_pkg::OFF_CONTROL_2)
                                    | hit(off, apm_pkg::OFF_CONTROL_3));

  // Only the second stage is read downstream
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      resume_meta_ff <= apm_pkg::RST_BIT;
      resume_sync_ff <= apm_pkg::RST_BIT;
    end
    else
    begin
      resume_meta_ff <= resume_event;
      resume_sync_ff <= resume_meta_ff;
    end
  end

  // Sleep/work state machine
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      apm_pkg::APM_WORKING:
        if (!wake_flag_ff && all_devices_asleep)
          nxt_state = apm_pkg::APM_SLEEPING;
      apm_pkg::APM_SLEEPING:
        if (wake_set)
          nxt_state = apm_pkg::APM_WORKING;
      default:
        nxt_state = apm_pkg::APM_WORKING;
    endcase
  end

  // Set wins over every clear below
  assign nxt_wake_flag   = wake_set | (wake_flag_ff & ~clr_wake & ~standby_expired);
  assign nxt_tick_flag   = tick_edge | (tick_carry_flag_ff & ~clr_tick);
  assign nxt_bm_flag     = busmaster_request_set | (busmaster_flag_ff & ~clr_bm);
  assign nxt_bm_request  = busmaster_request_set | (busmaster_request_bit_ff & ~clr_bm);
  assign nxt_gbl_flag    = firmware_release | (global_attention_flag_ff & ~clr_gbl);
  assign nxt_gbl_release = set_rls | (global_release_ff & ~firmware_event_clear);
  assign nxt_fw_flag     = set_rls | (firmware_event_flag_ff & ~firmware_event_clear);

  // Readback; unused bits and reserved bytes stay zero
  always_comb
  begin
    nxt_rdata = apm_pkg::ZERO_BYTE;
    if (in_block && hit(off, apm_pkg::OFF_STATUS_LOW))
    begin
      nxt_rdata[apm_pkg::BIT_TICK_FLAG] = tick_carry_flag_ff;
      nxt_rdata[apm_pkg::BIT_BM_FLAG]   = busmaster_flag_ff;
      nxt_rdata[apm_pkg::BIT_GBL_FLAG]  = global_attention_flag_ff;
    end
    else if (in_block && hit(off, apm_pkg::OFF_WAKE_STATUS))
      nxt_rdata[apm_pkg::BIT_WAKE_FLAG] = wake_flag_ff;
    else if (in_block && hit(off, apm_pkg::OFF_ENABLE_LOW))
    begin
      nxt_rdata[apm_pkg::BIT_TICK_EN] = tick_event_enable_ff;
      nxt_rdata[apm_pkg::BIT_GLOBAL_ATTENTION_ENABLE]  = global_attention_enable_ff;
    end
    else if (in_block && hit(off, apm_pkg::OFF_CONTROL_1))
    begin
      nxt_rdata[apm_pkg::BIT_ROUTE_SEL]   = event_route_select_ff;
      nxt_rdata[apm_pkg::BIT_BM_RELOAD]   = busmaster_reload_enable_ff;
      nxt_rdata[apm_pkg::BIT_GBL_RELEASE] = global_release_ff;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff                 <= apm_pkg::APM_WORKING;
      msb_prev_ff              <= apm_pkg::RST_BIT;
      wake_flag_ff             <= apm_pkg::RST_BIT;
      tick_carry_flag_ff       <= apm_pkg::RST_BIT;
      busmaster_flag_ff        <= apm_pkg::RST_BIT;
      busmaster_request_bit_ff <= apm_pkg::RST_BIT;
      global_attention_flag_ff <= apm_pkg::RST_BIT;
      global_release_ff        <= apm_pkg::RST_BIT;
      firmware_event_flag_ff   <= apm_pkg::RST_BIT;
      io_rdata                 <= apm_pkg::RST_BYTE;
    end
    else
    begin
      state_ff                 <= nxt_state;
      msb_prev_ff              <= counter_msb;
      wake_flag_ff             <= nxt_wake_flag;
      tick_carry_flag_ff       <= nxt_tick_flag;
      busmaster_flag_ff        <= nxt_bm_flag;
      busmaster_request_bit_ff <= nxt_bm_request;
      global_attention_flag_ff <= nxt_gbl_flag;
      global_release_ff        <= nxt_gbl_release;
      firmware_event_flag_ff   <= nxt_fw_flag;
      io_rdata                 <= io_req.rd ? nxt_rdata : apm_pkg::RST_BYTE;
    end
  end

  // Plain read/write enable and control bits
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tick_event_enable_ff       <= apm_pkg::RST_BIT;
      global_attention_enable_ff <= apm_pkg::RST_BIT;
      event_route_select_ff      <= apm_pkg::RST_BIT;
      busmaster_reload_enable_ff <= apm_pkg::RST_BIT;
    end
    else
    begin
      if (wr_en_lo)
      begin
        tick_event_enable_ff       <= io_req.wdata[apm_pkg::BIT_TICK_EN];
        global_attention_enable_ff <= io_req.wdata[apm_pkg::BIT_GLOBAL_ATTENTION_ENABLE];
      end
      if (wr_ctl1)
      begin
        event_route_select_ff      <= io_req.wdata[apm_pkg::BIT_ROUTE_SEL];
        busmaster_reload_enable_ff <= io_req.wdata[apm_pkg::BIT_BM_RELOAD];
      end
    end
  end

  // Levels, not pulses: held until software clears the status
  assign sci = event_route_select_ff & pm_event;
  assign smi = (~event_route_select_ff & alternate_route_enable & pm_event)
             | fw_smi;
  assign firmware_event_flag = firmware_event_flag_ff;
  assign system_sleeping     = (state_ff == apm_pkg::APM_SLEEPING);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_sleep_resume;
    (state_ff == apm_pkg::APM_SLEEPING) && resume_sync_ff;
  endsequence

  sequence s_wake_cleared;
    !wake_flag_ff && all_devices_asleep && (state_ff == apm_pkg::APM_WORKING);
  endsequence

  wake_sets_a: assert property (s_sleep_resume |=> wake_flag_ff)
    else $error("wake flag not set by resume while sleeping");
  wake_to_work_a: assert property (s_sleep_resume |=> !system_sleeping)
    else $error("system did not return to working");
  wake_w1c_a: assert property (clr_wake && !wake_set |=> !wake_flag_ff)
    else $error("wake flag not cleared by write one");
  wake_hold_a: assert property ($rose(wake_flag_ff) |-> $past(wake_set))
    else $error("wake flag set without hardware event");
  wake_expire_a: assert property (standby_expired && !wake_set |=> !wake_flag_ff)
    else $error("standby expiry did not clear wake flag");
  chip_sleep_a: assert property (s_wake_cleared |=> system_sleeping)
    else $error("chip did not enter sleep");
  tick_sci_a: assert property (tick_edge && tick_event_enable_ff && event_route_select_ff
                               && !wr_en_lo && !wr_ctl1 |=> sci)
    else $error("tick carry did not raise sci");
  tick_quiet_a: assert property (!tick_event_enable_ff && !busmaster_request_bit_ff
                                 && !global_attention_flag_ff |-> !sci)
    else $error("sci raised with tick disabled");
  gbl_sci_a: assert property (global_attention_flag_ff && global_attention_enable_ff
                              && event_route_select_ff |-> sci)
    else $error("global attention did not raise sci");
  alt_smi_a: assert property (pm_event && !event_route_select_ff && alternate_route_enable
                              |-> smi && !sci)
    else $error("event not routed to smi");
  bm_sci_a: assert property (busmaster_reload_enable_ff && busmaster_request_bit_ff
                             && event_route_select_ff |-> sci)
    else $error("bus master reload did not raise sci");
  rls_fw_a: assert property (set_rls |=> firmware_event_flag_ff && global_release_ff)
    else $error("global release did not set firmware flag");
  fw_smi_a: assert property (set_rls && firmware_event_enable ##1 firmware_event_enable
                             |-> smi)
    else $error("firmware event did not raise smi");
  // Bits 6 and 3 are reserved in every byte; flags sit at 4 and 5 of status low
  rsvd_zero_a: assert property ($past(io_req.rd) |-> (io_rdata & 8'h48) == 8'h00)
    else $error("reserved bits read non zero");
  rsvd_byte_a: assert property ($past(rd_rsvd) |-> io_rdata == apm_pkg::ZERO_BYTE)
    else $error("reserved byte read non zero");
  msb_flag_a: assert property (tick_edge |=> tick_carry_flag_ff)
    else $error("counter msb change missed");
  gbl_flag_a: assert property (firmware_release |=> global_attention_flag_ff)
    else $error("firmware release did not set global flag");
  bm_clear_a: assert property (clr_bm && !busmaster_request_set
                               |=> !busmaster_flag_ff && !busmaster_request_bit_ff)
    else $error("bus master flag write one did not clear both");
  // Only a host write can drop a held level, so two idle cycles keep it two edges
  sci_level_a: assert property (sci && !io_req.wr ##1 !io_req.wr |-> sci ##1 sci)
    else $error("sci dropped while status held");
  no_route_a: assert property (pm_event && !event_route_select_ff
                              && !alternate_route_enable && !firmware_event_flag_ff
                              |-> !sci && !smi)
    else $error("event signalled with no route enabled");
  tick_no_smi_a: assert property (!tick_event_enable_ff && !busmaster_request_bit_ff
                                  && !global_attention_flag_ff && !firmware_event_flag_ff
                                  |-> !smi)
    else $error("smi raised with tick disabled");
  rls_clear_a: assert property (firmware_event_clear && !set_rls
                                |=> !firmware_event_flag_ff && !global_release_ff)
    else $error("firmware flag clear did not drop release");
  gbl_w1c_a: assert property (clr_gbl && !firmware_release |=> !global_attention_flag_ff)
    else $error("global flag not cleared by write one");
  tick_w1c_a: assert property (clr_tick && !tick_edge |=> !tick_carry_flag_ff)
    else $error("tick flag not cleared by write one");
  bm_set_a: assert property (busmaster_request_set
                             |=> busmaster_request_bit_ff && busmaster_flag_ff)
    else $error("bus master request bit not set");

endmodule

// ===== bench/tb_apm_pm1_event_control.sv
// Purpose: Self-checking bench for the PM1 event and control byte group
// Assumes: Host I/O strobes as one-cycle pulses, read data one cycle after rd
// Notes:   Firmware side is driven directly on the block's ports
`timescale 1ns/1ns
module tb_apm_pm1_event_control;
  localparam logic [9:0] BASE = 10'h200;
  logic             clk;
  logic             resetn;
  apm_pkg::apm_io_s io_req;
  logic [7:0]       io_rdata;
  logic             counter_msb;
  logic             resume_event;
  logic             all_devices_asleep;
  logic             standby_expired;
  logic             firmware_release;
  logic             busmaster_request_set;
  logic             firmware_event_clear;
  logic             firmware_event_enable;
  logic             alternate_route_enable;
  logic             firmware_event_flag;
  logic             system_sleeping;
  logic             sci;
  logic             smi;
  int               error_cnt;
  int               checks;
  logic [3:0]       rsv [4] = '{4'h3, 4'h5, 4'h6, 4'h7};

  apm_pm1_event_control uut
  (
    .clk                    (clk),
    .resetn                 (resetn),
    .io_base                (BASE),
    .io_req                 (io_req),
    .io_rdata               (io_rdata),
    .counter_msb            (counter_msb),
    .resume_event           (resume_event),
    .all_devices_asleep     (all_devices_asleep),
    .standby_expired        (standby_expired),
    .firmware_release       (firmware_release),
    .busmaster_request_set  (busmaster_request_set),
    .firmware_event_clear   (firmware_event_clear),
    .firmware_event_enable  (firmware_event_enable),
    .alternate_route_enable (alternate_route_enable),
    .firmware_event_flag    (firmware_event_flag),
    .system_sleeping        (system_sleeping),
    .sci                    (sci),
    .smi                    (smi)
  );

  always #20 clk = ~clk;

  task automatic final_report();
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Strobe held over exactly one sampling edge, released on the next
  task automatic io_wr(input logic [3:0] off, input logic [7:0] d);
    @(posedge clk);
    io_req.wr    <= 1'b1;
    io_req.addr  <= BASE | {6'h00, off};
    io_req.wdata <= d;
    @(posedge clk);
    io_req.wr <= 1'b0;
    #1;
  endtask

  task automatic io_rd(input logic [3:0] off, input logic [7:0] exp, input string nm);
    @(posedge clk);
    io_req.rd   <= 1'b1;
    io_req.addr <= BASE | {6'h00, off};
    @(posedge clk);
    io_req.rd <= 1'b0;
    #1;
    chk(nm, exp, io_rdata);
  endtask

  // Toggle the counter top bit and let the flag settle
  task automatic flip_msb();
    @(posedge clk);
    counter_msb <= ~counter_msb;
    step(2);
  endtask

  initial
  begin
    #100000;
    error_cnt++;
    $display("[ERR] watchdog expected done seen timeout");
    final_report();
  end

  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    io_req = '0;
    {counter_msb, resume_event, all_devices_asleep, standby_expired} = 4'h0;
    {firmware_release, busmaster_request_set, firmware_event_clear} = 3'h0;
    {firmware_event_enable, alternate_route_enable} = 2'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    step(1);
    for (int i = 0; i < 8; i++) io_rd(4'(i), 8'h00, "reset value");
    chk("sci after reset", 8'h00, {7'h00, sci});
    io_wr(apm_pkg::OFF_ENABLE_LOW, 8'hff);
    io_rd(apm_pkg::OFF_ENABLE_LOW, 8'h21, "enable low");
    foreach (rsv[i])
    begin
      io_wr(rsv[i], 8'hff);
      io_rd(rsv[i], 8'h00, "reserved byte");
    end
    // Global release path to firmware
    @(posedge clk);
    firmware_event_enable <= 1'b1;
    io_wr(apm_pkg::OFF_CONTROL_1, 8'hff);
    io_rd(apm_pkg::OFF_CONTROL_1, 8'h07, "control 1");
    chk("firmware flag", 8'h01, {7'h00, firmware_event_flag});
    chk("smi on release", 8'h01, {7'h00, smi});
    chk("sci without request", 8'h00, {7'h00, sci});
    @(posedge clk);
    firmware_event_clear <= 1'b1;
    @(posedge clk);
    firmware_event_clear <= 1'b0;
    step(2);
    chk("firmware flag clear", 8'h00, {7'h00, firmware_event_flag});
    chk("smi released", 8'h00, {7'h00, smi});
    io_rd(apm_pkg::OFF_CONTROL_1, 8'h03, "control 1 after clear");
    @(posedge clk);
    firmware_event_enable <= 1'b0;
    // Tick carry on both edges of the counter top bit, routed to SCI
    io_wr(apm_pkg::OFF_CONTROL_1, 8'h01);
    flip_msb();
    chk("sci tick rise", 8'h01, {7'h00, sci});
    io_rd(apm_pkg::OFF_STATUS_LOW, 8'h01, "tick flag");
    io_wr(apm_pkg::OFF_STATUS_LOW, 8'h00);
    chk("sci kept on write zero", 8'h01, {7'h00, sci});
    io_wr(apm_pkg::OFF_STATUS_LOW, 8'h01);
    chk("sci tick clear", 8'h00, {7'h00, sci});
    flip_msb();
    chk("sci tick fall", 8'h01, {7'h00, sci});
    io_wr(apm_pkg::OFF_STATUS_LOW, 8'h01);
    // Tick enable off: flag still sets, no interrupt
    io_wr(apm_pkg::OFF_ENABLE_LOW, 8'h20);
    flip_msb();
    chk("sci tick disabled", 8'h00, {7'h00, sci});
    chk("smi tick disabled", 8'h00, {7'h00, smi});
    io_rd(apm_pkg::OFF_STATUS_LOW, 8'h01, "tick flag disabled");
    io_wr(apm_pkg::OFF_STATUS_LOW, 8'h01);
    // Alternate route to SMI
    io_wr(apm_pkg::OFF_ENABLE_LOW, 8'h21);
    io_wr(apm_pkg::OFF_CONTROL_1, 8'h00);
    @(posedge clk);
    alternate_route_enable <= 1'b1;
    flip_msb();
    chk("smi routed", 8'h01, {7'h00, smi});
    chk("sci not routed", 8'h00, {7'h00, sci});
    io_wr(apm_pkg::OFF_STATUS_LOW, 8'h01);
    chk("smi cleared", 8'h00, {7'h00, smi});
    // Neither route selected: the event is kept in status only
    @(posedge clk);
    alternate_route_enable <= 1'b0;
    flip_msb();
    chk("smi no route", 8'h00, {7'h00, smi});
    chk("sci no route", 8'h00, {7'h00, sci});
    io_wr(apm_pkg::OFF_STATUS_LOW, 8'h01);
    // Global attention from firmware release
    io_wr(apm_pkg::OFF_CONTROL_1, 8'h01);
    @(posedge clk);
    firmware_release <= 1'b1;
    @(posedge clk);
    firmware_release <= 1'b0;
    step(2);
    chk("sci global", 8'h01, {7'h00, sci});
    io_rd(apm_pkg::OFF_STATUS_LOW, 8'h20, "global flag");
    io_wr(apm_pkg::OFF_STATUS_LOW, 8'h20);
    chk("sci global clear", 8'h00, {7'h00, sci});
    // Bus master request with reload enable
    io_wr(apm_pkg::OFF_CONTROL_1, 8'h03);
    @(posedge clk);
    busmaster_request_set <= 1'b1;
    @(posedge clk);
    busmaster_request_set <= 1'b0;
    step(2);
    chk("sci bus master", 8'h01, {7'h00, sci});
    io_rd(apm_pkg::OFF_STATUS_LOW, 8'h10, "bus master flag");
    io_wr(apm_pkg::OFF_STATUS_LOW, 8'h10);
    chk("sci request cleared", 8'h00, {7'h00, sci});
    io_rd(apm_pkg::OFF_STATUS_LOW, 8'h00, "bus master cleared");
    // Sleep, resume, standby expiry
    @(posedge clk);
    all_devices_asleep <= 1'b1;
    step(3);
    chk("sleeping", 8'h01, {7'h00, system_sleeping});
    @(posedge clk);
    resume_event <= 1'b1;
    @(posedge clk);
    resume_event <= 1'b0;
    step(4);
    chk("woken", 8'h00, {7'h00, system_sleeping});
    io_rd(apm_pkg::OFF_WAKE_STATUS, 8'h80, "wake flag");
    io_wr(apm_pkg::OFF_WAKE_STATUS, 8'h7f);
    io_rd(apm_pkg::OFF_WAKE_STATUS, 8'h80, "wake write zero");
    @(posedge clk);
    standby_expired <= 1'b1;
    @(posedge clk);
    standby_expired <= 1'b0;
    step(2);
    chk("asleep again", 8'h01, {7'h00, system_sleeping});
    io_rd(apm_pkg::OFF_WAKE_STATUS, 8'h00, "wake expired");
    @(posedge clk);
    resume_event <= 1'b1;
    @(posedge clk);
    resume_event <= 1'b0;
    step(4);
    io_wr(apm_pkg::OFF_WAKE_STATUS, 8'h80);
    io_rd(apm_pkg::OFF_WAKE_STATUS, 8'h00, "wake host clear");
    step(2);
    chk("sleep after clear", 8'h01, {7'h00, system_sleeping});
    final_report();
  end
endmodule
